/* File: hw/two_wire_defs.svh */
// Register offsets, field positions and reset values of the two-wire master.
// Assumes a byte-addressed register port with 32-bit aligned words.
//
// How it works
// - Interrupt only from flags enabled by software.
// - Line idle flag set after bus activity.
// - Command ready when a command slot frees.
// - No new transfer while error flags set.
// - NACK sends STOP, command stays valid.
// - Clearing valid promotes the pending next command.
// - Held byte goes out in next transfer.
// - START then address with write bit.
// - Ninth pulse samples acknowledge, else address or data NACK.
// - Clock held low until holding byte valid.
// - Count down bytes, STOP at zero if asked.
// - Zero count command sends address only.
// - Outgoing byte written to low eight bits.
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH
// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define TW_CONTROL_OFS   8'h00
`define TW_CLKSETUP_OFS  8'h04
`define TW_SMBSETUP_OFS  8'h08
`define TW_CURCMD_OFS    8'h0c
`define TW_NXTCMD_OFS    8'h10
`define TW_STATUS_OFS    8'h14
`define TW_HOLDING_OFS   8'h18
`define TW_STCLEAR_OFS   8'h1c
`define TW_IRQEN_OFS     8'h20
`define TW_IRQDIS_OFS    8'h24
`define TW_IRQMASK_OFS   8'h28
// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define TW_CTL_ENABLE    0
`define TW_CTL_SWRESET   7
`define TW_CMD_READ      7
`define TW_CMD_START     8
`define TW_CMD_STOP      9
`define TW_CMD_VALID     15
`define TW_CMD_COUNT_LSB 16
`define TW_ST_CMDRDY     0
`define TW_ST_TXFREE     1
`define TW_ST_DONE       3
`define TW_ST_IDLE       4
`define TW_ST_ADDRNACK   8
`define TW_ST_DATANACK   9
`define TW_ST_ARBLOST    10
`define TW_WORD_RST      32'h00000000
`endif

/* File: hw/two_wire_pkg.sv */
// Types shared by the two-wire master.
// Assumes the constants header is included by whoever needs offsets.
package two_wire_pkg;
   typedef logic [7:0]  addr_t;
   typedef logic [31:0] word_t;
   typedef enum logic [6:0] {
      L_IDLE  = 7'h01,
      L_START = 7'h02,
      L_BIT   = 7'h04,
      L_ACK   = 7'h08,
      L_WAIT  = 7'h10,
      L_STOP  = 7'h20,
      L_DONE  = 7'h40
   } link_state_t;
   typedef enum logic [1:0] {
      RES_OK   = 2'h0,
      RES_ADDRESS_NACK_FLAG = 2'h1,
      RES_DATA_NACK_FLAG = 2'h2,
      RES_ARB  = 2'h3
   } result_t;
endpackage : two_wire_pkg

/* File: hw/two_wire_master.sv */
// Two-wire bus master: register port on sys_clk_in, bit engine on link_clk_in.
// Assumes open-drain pins resolved outside and pulled high when released.
`include "two_wire_defs.svh"
module two_wire_master (
   input  wire logic                sys_clk_in,
   input  wire logic                resetn_in,
   input  wire logic                link_clk_in,
   input  wire two_wire_pkg::addr_t addr_in,
   input  wire two_wire_pkg::word_t wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output two_wire_pkg::word_t      rdata_out,
   output logic                     irq_out,
   input  wire logic                scl_in,
   output logic                     scl_out,
   output logic                     scl_oe_out,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe_out
);
   import two_wire_pkg::*;

   // ---------------------------------------------------------------------------
   // System-side state
   // ---------------------------------------------------------------------------
   logic        en_q, srst_q;
   word_t       clkset_q, smbset_q, cur_q, nxt_q, xcmd_q, rdata_q;
   logic [7:0]  xqtr_q, thr_q, byte_q;
   logic        thr_full_q, byte_ack_q, xreq_q, irq_q;
   logic [10:0] flags_q, imr_q, status;
   logic        done_m, done_s, breq_m, breq_s, idle_m, idle_s, sack_m, sack_s;
   // Link-side state
   link_state_t st_q;
   logic [1:0]  ph_q;
   logic [7:0]  cnt_q, qtr_q, sh_q, nb_q;
   logic [2:0]  bitn_q;
   logic        req_m, req_l, ack_m, ack_l, srst_m, srst_l;
   logic        scl_m, scl_l, sda_m, sda_l;
   logic        scl_oe_q, sda_oe_q, done_q, breq_q, held_q, idle_q, sack_q;
   logic        addr_ph_q, stop_q;
   result_t     res_q;
   logic        wr_ctl, wr_cur, wr_nxt, wr_thr, promote, go, fin, take, step;
   logic        errs;

   // Decodes a write strobe for one register offset.
   function automatic logic hit(input addr_t a, input addr_t ofs);
      hit = (a == ofs);
   endfunction : hit

   // ---------------------------------------------------------------------------
   // Register port decode
   // ---------------------------------------------------------------------------
   // Write strobes and handshake terms.
   assign wr_ctl  = wr_in && hit(addr_in, `TW_CONTROL_OFS);
   assign wr_cur  = wr_in && hit(addr_in, `TW_CURCMD_OFS);
   assign wr_nxt  = wr_in && hit(addr_in, `TW_NXTCMD_OFS);
   assign wr_thr  = wr_in && hit(addr_in, `TW_HOLDING_OFS);
   assign errs    = |flags_q[`TW_ST_ARBLOST:`TW_ST_ADDRNACK];
   assign promote = !cur_q[`TW_CMD_VALID] && nxt_q[`TW_CMD_VALID] && !wr_cur;
   assign go      = en_q && cur_q[`TW_CMD_VALID] && !cur_q[`TW_CMD_READ] && !xreq_q
                    && !done_s && !errs && !srst_q && !sack_s;
   assign fin     = xreq_q && done_s;
   assign take    = breq_s && thr_full_q && !byte_ack_q && !srst_q;

   // Live status word; sticky bits live in flags_q.
   always_comb begin
      status = flags_q;
      status[`TW_ST_CMDRDY] = !cur_q[`TW_CMD_VALID] || !nxt_q[`TW_CMD_VALID];
      status[`TW_ST_TXFREE] = !thr_full_q;
      status[`TW_ST_IDLE]   = idle_s;
   end

   // Control, timing setup and software reset request.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_q     <= 1'b0;
         srst_q   <= 1'b0;
         clkset_q <= `TW_WORD_RST;
         smbset_q <= `TW_WORD_RST;
      end else begin
         if (wr_ctl) begin
            en_q <= wdata_in[`TW_CTL_ENABLE];
         end
         if (wr_ctl && wdata_in[`TW_CTL_SWRESET]) begin
            srst_q <= 1'b1;
         end else if (sack_s) begin
            srst_q <= 1'b0;
         end
         if (wr_in && hit(addr_in, `TW_CLKSETUP_OFS)) begin
            clkset_q <= wdata_in;
         end
         if (wr_in && hit(addr_in, `TW_SMBSETUP_OFS)) begin
            smbset_q <= wdata_in;
         end
      end
   end

   // Current and next command slots.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cur_q <= `TW_WORD_RST;
         nxt_q <= `TW_WORD_RST;
      end else if (srst_q) begin
         cur_q <= `TW_WORD_RST;
         nxt_q <= `TW_WORD_RST;
      end else begin
         if (wr_cur) begin
            cur_q <= wdata_in;
         end else if (fin && res_q == RES_OK) begin
            cur_q[`TW_CMD_VALID] <= 1'b0;
         end else if (promote) begin
            cur_q <= nxt_q;
         end
         if (wr_nxt) begin
            nxt_q <= wdata_in;
         end else if (promote) begin
            nxt_q[`TW_CMD_VALID] <= 1'b0;
         end
      end
   end

   // Transfer request: command and timing frozen while the request stands.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xreq_q <= 1'b0;
         xcmd_q <= `TW_WORD_RST;
         xqtr_q <= 8'h00;
      end else if (srst_q) begin
         xreq_q <= 1'b0;
      end else if (go) begin
         xreq_q <= 1'b1;
         xcmd_q <= cur_q;
         xqtr_q <= clkset_q[7:0];
      end else if (fin) begin
         xreq_q <= 1'b0;
      end
   end

   // Holding register and byte handshake toward the link.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         thr_q      <= 8'h00;
         thr_full_q <= 1'b0;
         byte_q     <= 8'h00;
         byte_ack_q <= 1'b0;
      end else if (srst_q) begin
         thr_full_q <= 1'b0;
         byte_ack_q <= 1'b0;
      end else begin
         if (wr_thr) begin
            thr_q      <= wdata_in[7:0];
            thr_full_q <= 1'b1;
         end else if (take) begin
            thr_full_q <= 1'b0;
         end
         if (take) begin
            byte_q     <= thr_q;
            byte_ack_q <= 1'b1;
         end else if (!breq_s) begin
            byte_ack_q <= 1'b0;
         end
      end
   end

   // Sticky flags; a set in the clearing cycle wins.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_q <= 11'h000;
      end else if (srst_q) begin
         flags_q <= 11'h000;
      end else begin
         if (fin) begin
            flags_q[`TW_ST_DONE]     <= 1'b1;
            flags_q[`TW_ST_ADDRNACK] <= (res_q == RES_ADDRESS_NACK_FLAG) || flags_q[`TW_ST_ADDRNACK];
            flags_q[`TW_ST_DATANACK] <= (res_q == RES_DATA_NACK_FLAG) || flags_q[`TW_ST_DATANACK];
            flags_q[`TW_ST_ARBLOST]  <= (res_q == RES_ARB) || flags_q[`TW_ST_ARBLOST];
         end else if (wr_in && hit(addr_in, `TW_STCLEAR_OFS)) begin
            flags_q <= flags_q & ~wdata_in[10:0];
         end
      end
   end

   // Interrupt mask and request.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         imr_q <= 11'h000;
         irq_q <= 1'b0;
      end else begin
         if (wr_in && hit(addr_in, `TW_IRQEN_OFS)) begin
            imr_q <= imr_q | wdata_in[10:0];
         end else if (wr_in && hit(addr_in, `TW_IRQDIS_OFS)) begin
            imr_q <= imr_q & ~wdata_in[10:0];
         end
         irq_q <= |(status & imr_q);
      end
   end

   // Read data, valid in the cycle after the read strobe only.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_q <= `TW_WORD_RST;
      end else if (!rd_in) begin
         rdata_q <= `TW_WORD_RST;
      end else begin
         unique case (addr_in)
            `TW_CONTROL_OFS:  rdata_q <= {31'h0, en_q};
            `TW_CLKSETUP_OFS: rdata_q <= clkset_q;
            `TW_SMBSETUP_OFS: rdata_q <= smbset_q;
            `TW_CURCMD_OFS:   rdata_q <= cur_q;
            `TW_NXTCMD_OFS:   rdata_q <= nxt_q;
            `TW_STATUS_OFS:   rdata_q <= {21'h0, status};
            `TW_IRQMASK_OFS:  rdata_q <= {21'h0, imr_q};
            default:          rdata_q <= `TW_WORD_RST;
         endcase
      end
   end

   // Synchronisers of link-side levels into the system domain.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {done_m, done_s, breq_m, breq_s} <= 4'h0;
         {idle_m, idle_s, sack_m, sack_s} <= 4'h0;
      end else begin
         done_m <= done_q;
         done_s <= done_m;
         breq_m <= breq_q;
         breq_s <= breq_m;
         idle_m <= idle_q;
         idle_s <= idle_m;
         sack_m <= sack_q;
         sack_s <= sack_m;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out   = irq_q;

   // ---------------------------------------------------------------------------
   // Link domain
   // ---------------------------------------------------------------------------
   // Synchronisers of requests and bus pins into the link domain.
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {req_m, req_l, ack_m, ack_l, srst_m, srst_l} <= 6'h00;
         {scl_m, scl_l, sda_m, sda_l} <= 4'hf;
      end else begin
         req_m  <= xreq_q;
         req_l  <= req_m;
         ack_m  <= byte_ack_q;
         ack_l  <= ack_m;
         srst_m <= srst_q;
         srst_l <= srst_m;
         scl_m  <= scl_in;
         scl_l  <= scl_m;
         sda_m  <= sda_in;
         sda_l  <= sda_m;
      end
   end

   // A phase steps when its quarter period expires; clock stretching holds it.
   assign step = (cnt_q == 8'h00) && !(ph_q == 2'h2 && !scl_l);

   // Quarter-period counter.
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= 8'h00;
      end else if (st_q == L_IDLE || st_q == L_WAIT || step || (ph_q == 2'h2 && !scl_l)) begin
         cnt_q <= (st_q == L_IDLE) ? xqtr_q : qtr_q;
      end else begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   // Bit engine: START, address, data, acknowledge and STOP.
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q      <= L_IDLE;
         ph_q      <= 2'h0;
         scl_oe_q  <= 1'b0;
         sda_oe_q  <= 1'b0;
         sh_q      <= 8'h00;
         nb_q      <= 8'h00;
         bitn_q    <= 3'h0;
         qtr_q     <= 8'h00;
         done_q    <= 1'b0;
         breq_q    <= 1'b0;
         held_q    <= 1'b0;
         addr_ph_q <= 1'b0;
         stop_q    <= 1'b0;
         res_q     <= RES_OK;
      end else if (srst_l) begin
         st_q     <= L_IDLE;
         ph_q     <= 2'h0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         done_q   <= 1'b0;
         breq_q   <= 1'b0;
         held_q   <= 1'b0;
      end else begin
         unique case (st_q)
            L_IDLE: begin
               ph_q <= 2'h0;
               if (req_l) begin
                  sh_q      <= {xcmd_q[6:0], 1'b0};
                  nb_q      <= xcmd_q[`TW_CMD_COUNT_LSB +: 8];
                  stop_q    <= xcmd_q[`TW_CMD_STOP];
                  qtr_q     <= xqtr_q;
                  bitn_q    <= 3'h7;
                  addr_ph_q <= 1'b1;
                  res_q     <= RES_OK;
                  if (xcmd_q[`TW_CMD_START]) begin
                     st_q <= L_START;
                  end else if (xcmd_q[`TW_CMD_COUNT_LSB +: 8] != 8'h00) begin
                     st_q <= L_WAIT;
                  end else if (xcmd_q[`TW_CMD_STOP]) begin
                     st_q <= L_STOP;
                  end else begin
                     st_q <= L_DONE;
                  end
               end
            end
            L_START: begin
               if (step) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: sda_oe_q <= 1'b0;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b1;
                     2'h3: begin
                        scl_oe_q <= 1'b1;
                        st_q     <= L_BIT;
                     end
                  endcase
               end
            end
            L_BIT: begin
               if (step) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: sda_oe_q <= !sh_q[7];
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: begin
                        if (sh_q[7] && !sda_l) begin
                           scl_oe_q <= 1'b0; // Lost the bus: release both lines.
                           sda_oe_q <= 1'b0;
                           held_q   <= 1'b0;
                           res_q    <= RES_ARB;
                           st_q     <= L_DONE;
                        end
                     end
                     2'h3: begin
                        scl_oe_q <= 1'b1;
                        sh_q     <= {sh_q[6:0], 1'b0};
                        bitn_q   <= bitn_q - 3'h1;
                        if (bitn_q == 3'h0) begin
                           st_q <= L_ACK;
                        end
                     end
                  endcase
               end
            end
            L_ACK: begin
               if (step) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: sda_oe_q <= 1'b0;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: begin
                        if (sda_l) begin
                           res_q <= addr_ph_q ? RES_ADDRESS_NACK_FLAG : RES_DATA_NACK_FLAG;
                        end
                     end
                     2'h3: begin
                        scl_oe_q  <= 1'b1;
                        addr_ph_q <= 1'b0;
                        if (res_q != RES_OK) begin
                           st_q <= L_STOP;
                        end else if (nb_q != 8'h00) begin
                           st_q <= L_WAIT;
                        end else if (stop_q) begin
                           st_q <= L_STOP;
                        end else begin
                           held_q <= 1'b1;
                           st_q   <= L_DONE;
                        end
                     end
                  endcase
               end
            end
            L_WAIT: begin
               ph_q <= 2'h0;
               if (!breq_q && !ack_l) begin
                  breq_q <= 1'b1;
               end else if (breq_q && ack_l) begin
                  breq_q <= 1'b0;
                  sh_q   <= byte_q;
                  nb_q   <= nb_q - 8'h01;
                  bitn_q <= 3'h7;
                  st_q   <= L_BIT;
               end
            end
            L_STOP: begin
               if (step) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: sda_oe_q <= 1'b1;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b0;
                     2'h3: begin
                        held_q <= 1'b0;
                        st_q   <= L_DONE;
                     end
                  endcase
               end
            end
            L_DONE: begin
               done_q <= req_l;
               if (done_q && !req_l) begin
                  st_q <= L_IDLE;
               end
            end
         endcase
      end
   end

   // Link-side status levels sent back to the system domain.
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         idle_q <= 1'b0;
         sack_q <= 1'b0;
      end else begin
         idle_q <= (st_q == L_IDLE) && !held_q && scl_l && sda_l;
         sack_q <= srst_l;
      end
   end

   // Open-drain pins: drive low only.
   assign scl_out    = 1'b0;
   assign sda_out    = 1'b0;
   assign scl_oe_out = scl_oe_q;
   assign sda_oe_out = sda_oe_q;

endmodule : two_wire_master

/* File: tb/two_wire_master_assertions.sv */
// Port assertions of the two-wire master, bound to every instance.
// Assumes scl_in and sda_in carry the resolved, pulled-up line levels.
module two_wire_master_assertions (
   input wire logic                sys_clk_in,
   input wire logic                resetn_in,
   input wire logic                link_clk_in,
   input wire two_wire_pkg::addr_t addr_in,
   input wire two_wire_pkg::word_t wdata_in,
   input wire logic                wr_in,
   input wire logic                rd_in,
   input wire two_wire_pkg::word_t rdata_out,
   input wire logic                irq_out,
   input wire logic                scl_in,
   input wire logic                scl_out,
   input wire logic                scl_oe_out,
   input wire logic                sda_in,
   input wire logic                sda_out,
   input wire logic                sda_oe_out
);
   import two_wire_pkg::*;
   logic       scl_q;
   logic       sda_q;
   logic       stop_q;
   logic       en_q;
   logic [3:0] cnt_q;
   logic       rise;
   assign rise = !scl_q && scl_in;
   // Line history, pulse count since START and STOP detection.
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         stop_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else begin
         scl_q  <= scl_in;
         sda_q  <= sda_in;
         stop_q <= scl_q && scl_in && !sda_q && sda_in;
         if (scl_q && scl_in && sda_q && !sda_in) begin
            cnt_q <= 4'h0;
         end else if (rise) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end
   // Notes whether software ever set an interrupt mask bit.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_q <= 1'b0;
      end else if (wr_in && addr_in == 8'h20 && wdata_in != 32'h0) begin
         en_q <= 1'b1;
      end
   end
   a_ack_released: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
      rise && cnt_q == 4'h8 |-> !sda_oe_out) else $error("Data driven in ack pulse.");
   a_nack_stops: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
      rise && cnt_q == 4'h8 && sda_in |-> ##[1:60] stop_q) else $error("No STOP after nack.");
   a_irq_needs_mask: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !en_q |-> !irq_out) else $error("Irq without mask.");
   a_holding_reads_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      rd_in && addr_in == 8'h18 |=> rdata_out == 32'h0) else $error("Holding readable.");
   a_read_idle_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !$past(rd_in) |-> rdata_out == 32'h0) else $error("Read data outside slot.");
   a_status_reserved: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      rd_in && addr_in == 8'h14 |=> rdata_out[31:11] == 21'h0) else $error("Status high bits.");
   a_swreset_frees: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wr_in && addr_in == 8'h00 && wdata_in[7] |-> ##[1:60] !scl_oe_out && !sda_oe_out)
      else $error("Bus held after soft reset.");
   a_open_drain: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      scl_out == 1'b0 && sda_out == 1'b0) else $error("Pin driven high.");
endmodule : two_wire_master_assertions
bind two_wire_master two_wire_master_assertions chk_u (.sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in), .link_clk_in(link_clk_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out));

/* File: tb/two_wire_slave_model.sv */
// Behavioural slave on the two-wire bus: acknowledges each byte unless told to refuse the address, and logs each byte.
// Assumes the bench resolves both open-drain lines with pull-ups.
module two_wire_slave_model (
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic nack_addr_in,
   output logic      pull_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] shift_q;
   logic [7:0] log_q[$];
   int         bits_q;
   int         idx_q;
   // Released at start; the pull-up then shows on the line.
   initial begin
      pull_out = 1'b0;
      bits_q   = 0;
      idx_q    = 0;
   end
   // A START restarts bit and byte counting.
   always @(negedge sda_in) begin
      if (scl_in) begin
         bits_q = 0;
         idx_q  = 0;
      end
   end
   // Bits are taken MSB first as the clock rises.
   always @(posedge scl_in) begin
      if (bits_q < 8) begin
         shift_q = {shift_q[6:0], sda_in};
      end
      bits_q = bits_q + 1;
   end
   // Acknowledge is pulled for the ninth pulse, refused on request for the address.
   always @(negedge scl_in) begin
      if (bits_q == 8) begin
         log_q.push_back(shift_q);
         pull_out = !(idx_q == 0 && nack_addr_in);
         idx_q    = idx_q + 1;
      end else if (bits_q == 9) begin
         pull_out = 1'b0;
         bits_q   = 0;
      end
   end
endmodule : two_wire_slave_model

/* File: tb/two_wire_master_test.sv */
// Register-level tests of the two-wire master against a behavioural slave.
// Assumes the design, its package, the checker and the slave model compile first.
module two_wire_master_test import two_wire_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic  sys_clk;
   logic  link_clk;
   logic  resetn;
   addr_t addr;
   word_t wdata;
   logic  wr_s;
   logic  rd_s;
   word_t rdata;
   word_t s;
   logic  irq;
   logic  scl_oe;
   logic  sda_oe;
   logic  scl_o;
   logic  sda_o;
   logic  nack_addr;
   logic  pull;
   int    n_mismatch;
   int    compares;
   wire   scl_w = scl_oe ? scl_o : 1'b1;
   wire   sda_w = !(pull || (sda_oe && !sda_o));
   two_wire_master dut_u (.sys_clk_in(sys_clk), .resetn_in(resetn), .link_clk_in(link_clk),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
      .irq_out(irq), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe_out(sda_oe));
   two_wire_slave_model slave_u (.scl_in(scl_w), .sda_in(sda_w), .nack_addr_in(nack_addr),
      .pull_out(pull));
   // System clock of 20 ns.
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = !sys_clk;
   end
   // Link clock of 125 ns, offset from the system clock.
   initial begin
      link_clk = 1'b0;
      #7;
      forever #62.5 link_clk = !link_clk;
   end
   function automatic word_t mk(input logic [6:0] a, input logic [7:0] n);
      return {8'h00, n, 1'b1, 5'h00, 1'b1, 1'b1, 1'b0, a};
   endfunction : mk
   task automatic wr(input addr_t a, input word_t d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input addr_t a, output word_t d);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic chk(input string what, input word_t exp, input word_t got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Polls one status bit with a bounded number of reads.
   task automatic wait_st(input int b);
      int i;
      for (i = 0; i < 3000; i++) begin
         rd(8'h14, s);
         if (s[b] === 1'b1) break;
      end
      chk("status wait", 32'h1, {31'h0, s[b]});
   endtask : wait_st
   task automatic log_chk(input int n, input logic [23:0] e);
      int i;
      chk("byte count", word_t'(n), word_t'(slave_u.log_q.size()));
      for (i = 0; i < n; i++) begin
         chk("line byte", {24'h0, e[8*(n-1-i) +: 8]}, {24'h0, slave_u.log_q[i]});
      end
      slave_u.log_q.delete();
   endtask : log_chk
   task automatic final_report;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // Cuts a hang short past the expected run time.
   initial begin
      #1000000;
      n_mismatch++;
      $display("Error watchdog expected done seen hung");
      final_report();
   end
   // Transfers, refusals and soft reset.
   initial begin
      resetn     = 1'b0;
      addr       = 8'h00;
      wdata      = 32'h0;
      wr_s       = 1'b0;
      rd_s       = 1'b0;
      nack_addr  = 1'b0;
      n_mismatch = 0;
      compares   = 0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h1);
      wr(8'h0c, mk(7'h2c, 8'h02));
      repeat (800) @(posedge sys_clk);
      #1 chk("clock held low", 32'h1, {31'h0, scl_oe});
      rd(8'h14, s);
      chk("holding free", 32'h1, {31'h0, s[1]});
      wr(8'h18, 32'hffffff3c);
      repeat (100) @(posedge sys_clk);
      wait_st(1);
      wr(8'h18, 32'h5a);
      wait_st(3);
      log_chk(3, 24'h583c5a);
      wait_st(4);
      chk("slot ready", 32'h1, {31'h0, s[0]});
      wr(8'h20, 32'h8);
      repeat (3) @(posedge sys_clk);
      #1 chk("irq on", 32'h1, {31'h0, irq});
      wr(8'h24, 32'h8);
      repeat (3) @(posedge sys_clk);
      #1 chk("irq off", 32'h0, {31'h0, irq});
      wr(8'h1c, 32'h8);
      wr(8'h0c, mk(7'h2c, 8'h00));
      wait_st(3);
      log_chk(1, 24'h58);
      nack_addr <= 1'b1;
      wr(8'h1c, 32'h8);
      wr(8'h18, 32'h77);
      wr(8'h0c, mk(7'h2c, 8'h01));
      wr(8'h10, mk(7'h11, 8'h01));
      wait_st(8);
      rd(8'h0c, s);
      chk("command kept", mk(7'h2c, 8'h01), s);
      nack_addr <= 1'b0;
      repeat (1000) @(posedge sys_clk);
      log_chk(1, 24'h58);
      wr(8'h0c, 32'h0);
      rd(8'h0c, s);
      chk("next promoted", mk(7'h11, 8'h01), s);
      wr(8'h1c, 32'h108);
      wait_st(3);
      log_chk(2, 24'h2277);
      wr(8'h18, 32'h99);
      wr(8'h00, 32'h80);
      repeat (40) @(posedge sys_clk);
      rd(8'h14, s);
      chk("status after reset", 32'h3, s & 32'h703);
      rd(8'h30, s);
      chk("unmapped read", 32'h0, s);
      rd(8'h18, s);
      chk("holding read", 32'h0, s);
      wr(8'h00, 32'h1);
      wr(8'h1c, 32'h8);
      wr(8'h0c, mk(7'h2c, 8'h01));
      repeat (800) @(posedge sys_clk);
      wr(8'h18, 32'h42);
      wait_st(3);
      log_chk(2, 24'h5842);
      final_report();
   end
endmodule : two_wire_master_test
